// ===== bdh_demand.sv
// demand handling inside the communication interface unit
// assumes coupler inputs synchronous to mclk, strobe one cycle wide
`include "bdh_regs.svh"

module bdh_demand (
    input wire logic mclk,
    input wire logic rst_n,
    input bdh_pkg::bdh_cfg_t cfg,
    input bdh_pkg::bdh_cpl_t cpl,
    input wire logic demandPending,
    output bdh_pkg::bdh_line_t line,
    output bdh_pkg::bdh_diu_t diu,
    output bdh_pkg::bdh_hdr_t hdr
);
    import bdh_pkg::*;

    // ----------------------------------------------------------
    // reset release
    // ----------------------------------------------------------
    logic rstMeta_q;
    logic rstSync_q;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_q <= 1'h0;
            rstSync_q <= 1'h0;
        end
        else
        begin
            rstMeta_q <= 1'h1;
            rstSync_q <= rstMeta_q;
        end
    end

    // ----------------------------------------------------------
    // role, caught once after release
    // ----------------------------------------------------------
    // a station may not change role while running: two masters
    // on one bus would fight over the command line
    logic roleSeen_q, roleSeen_d;
    logic isMaster_q, isMaster_d;

    always_comb
    begin
        roleSeen_d = 1'h1;
        isMaster_d = roleSeen_q ? isMaster_q : cfg.isMaster;
    end

    always_ff @(posedge mclk or negedge rstSync_q)
    begin
        if (!rstSync_q)
        begin
            roleSeen_q <= 1'h0;
            isMaster_q <= 1'h0;
        end
        else
        begin
            roleSeen_q <= roleSeen_d;
            isMaster_q <= isMaster_d;
        end
    end

    // ----------------------------------------------------------
    // bit time tracking
    // ----------------------------------------------------------
    logic msgPrev_q, msgPrev_d;
    logic [4:0] bitCnt_q, bitCnt_d;
    logic [5:0] gapCnt_q, gapCnt_d;
    logic msgStart, msgEnd, gapFault, shortMsg, inSlot;

    assign msgStart = cpl.msgInProgress & ~msgPrev_q;
    assign msgEnd = ~cpl.msgInProgress & msgPrev_q;
    assign shortMsg = msgEnd & (bitCnt_q < `BDH_CMD_MIN_BITS);
    assign inSlot = cpl.msgInProgress & (bitCnt_q < `BDH_DEMAND_MAX);
    // a stalled sender inside a frame counts as a broken message
    assign gapFault = cpl.msgInProgress & ~cpl.rxStrobe
        & (gapCnt_q == `BDH_GAP_CYC - 6'h1);

    always_comb
    begin
        msgPrev_d = cpl.msgInProgress;
        bitCnt_d = bitCnt_q;
        gapCnt_d = gapCnt_q;
        if (!cpl.msgInProgress)
        begin
            bitCnt_d = 5'h00;
        end
        else if (cpl.rxStrobe && bitCnt_q != `BDH_CNT_SAT)
        begin
            bitCnt_d = bitCnt_q + 5'h01;
        end
        if (!cpl.msgInProgress || cpl.rxStrobe)
        begin
            gapCnt_d = 6'h00;
        end
        else if (gapCnt_q != `BDH_GAP_CYC)
        begin
            gapCnt_d = gapCnt_q + 6'h01;
        end
    end

    always_ff @(posedge mclk or negedge rstSync_q)
    begin
        if (!rstSync_q)
        begin
            msgPrev_q <= 1'h0;
            bitCnt_q <= 5'h00;
            gapCnt_q <= 6'h00;
        end
        else
        begin
            msgPrev_q <= msgPrev_d;
            bitCnt_q <= bitCnt_d;
            gapCnt_q <= gapCnt_d;
        end
    end

    // ----------------------------------------------------------
    // slave end: reply line marking
    // ----------------------------------------------------------
    bdh_line_t line_q, line_d;
    logic numValid, slaveDemand, markNow;

    assign numValid = (cfg.demandNum >= `BDH_DEMAND_MIN)
        & (cfg.demandNum <= `BDH_DEMAND_MAX);
    // no demand until the role is known, else a master glitches once
    assign slaveDemand = roleSeen_q & ~isMaster_q & cfg.isActive
        & demandPending;
    assign markNow = slaveDemand & cfg.level2En & numValid & inSlot
        & (bitCnt_q == 5'(cfg.demandNum - 5'h01));

    always_comb
    begin
        line_d.replyOut = markNow;
        line_d.replyOe = markNow;
        // level one stays on whenever an active slave has a demand pending
        line_d.globalDemand = slaveDemand;
    end

    always_ff @(posedge mclk or negedge rstSync_q)
    begin
        if (!rstSync_q)
        begin
            line_q <= '0;
        end
        else
        begin
            line_q <= line_d;
        end
    end

    assign line = line_q;

    // ----------------------------------------------------------
    // master end: collection and delivery
    // ----------------------------------------------------------
    bdh_state_t st_q, st_d;
    logic [`BDH_DEMAND_MAX-1:0] word_q, word_d;
    logic [4:0] idx_q, idx_d;
    logic [2:0] div_q, div_d;
    logic globalSeen_q, globalSeen_d;
    bdh_diu_t diu_q, diu_d;
    bdh_hdr_t hdr_q, hdr_d;
    logic tick, takeBit, crossErr, deliverDone;

    assign tick = (div_q == `BDH_DIU_DIV - 3'h1);
    assign takeBit = isMaster_q & cpl.rxStrobe & inSlot;
    assign deliverDone = (st_q == BDH_DELIVER) & tick
        & (idx_q == `BDH_DEMAND_MAX - 5'h01);
    // a demand bit without the global line, or the reverse, is an error
    assign crossErr = msgEnd & isMaster_q & cfg.level2En
        & ((word_q != '0) != globalSeen_q);

    always_comb
    begin
        st_d = st_q;
        word_d = word_q;
        idx_d = idx_q;
        div_d = tick ? 3'h0 : div_q + 3'h1;
        globalSeen_d = globalSeen_q;
        hdr_d = hdr_q;
        diu_d = diu_q;
        diu_d.rxStrobe = 1'h0;
        if (msgStart)
        begin
            word_d = '0;
            globalSeen_d = 1'h0;
        end
        if (cpl.msgInProgress && cpl.globalIn)
        begin
            globalSeen_d = 1'h1;
        end
        if (takeBit)
        begin
            word_d[bitCnt_q] = cpl.replyIn;
            if (bitCnt_q < `BDH_KIND_FIRST)
            begin
                hdr_d.stationSel[3'(`BDH_KIND_FIRST - 5'h01 - bitCnt_q)]
                    = cpl.rxData;
            end
            else if (bitCnt_q < `BDH_KIND_END)
            begin
                hdr_d.msgKind[3'(`BDH_KIND_END - 5'h01 - bitCnt_q)]
                    = cpl.rxData;
            end
        end
        // set wins over clear on the service flag
        if (isMaster_q && cpl.globalIn)
        begin
            diu_d.demandPresent = 1'h1;
        end
        else if (cfg.level2En ? deliverDone : 1'h1)
        begin
            diu_d.demandPresent = 1'h0;
        end
        if (gapFault || crossErr)
        begin
            diu_d.rxFaultFlag = 1'h1;
        end
        else if (msgStart)
        begin
            diu_d.rxFaultFlag = 1'h0;
        end
        if (shortMsg)
        begin
            diu_d.rxSizeFlag = 1'h1;
        end
        else if (msgStart)
        begin
            diu_d.rxSizeFlag = 1'h0;
        end
        case (st_q)
            BDH_IDLE:
            begin
                // the returned command goes on to the device side
                diu_d.rxData = cpl.rxData;
                diu_d.rxStrobe = isMaster_q & cpl.rxStrobe
                    & cpl.msgInProgress;
                if (msgEnd && isMaster_q && cfg.level2En
                    && diu_q.demandPresent && !shortMsg)
                begin
                    st_d = BDH_DELIVER;
                    idx_d = 5'h00;
                end
            end
            BDH_DELIVER:
            begin
                if (tick)
                begin
                    diu_d.rxData = word_q[idx_q];
                    diu_d.rxStrobe = 1'h1;
                    idx_d = idx_q + 5'h01;
                    if (deliverDone)
                    begin
                        st_d = BDH_IDLE;
                    end
                end
            end
            default:
            begin
                st_d = BDH_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstSync_q)
    begin
        if (!rstSync_q)
        begin
            st_q <= BDH_IDLE;
            word_q <= '0;
            idx_q <= 5'h00;
            div_q <= 3'h0;
            globalSeen_q <= 1'h0;
            diu_q <= '0;
            hdr_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            word_q <= word_d;
            idx_q <= idx_d;
            div_q <= div_d;
            globalSeen_q <= globalSeen_d;
            diu_q <= diu_d;
            hdr_q <= hdr_d;
        end
    end

    assign diu = diu_q;
    assign hdr = hdr_q;

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    localparam int DELIVER_MAX = 100;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstSync_q);

    chk_global_raises_flag: assert property (
        isMaster_q && cpl.globalIn |=> diu.demandPresent)
        else $error("global demand did not raise service flag");

    chk_reply_slot_match: assert property (
        line.replyOe |-> $past(bitCnt_q) == 5'($past(cfg.demandNum) - 5'h01)
            && $past(cpl.msgInProgress))
        else $error("reply bit outside own bit time");

    chk_mark_with_global: assert property (
        line.replyOe |-> line.globalDemand)
        else $error("demand bit without global demand");

    chk_master_never_marks: assert property (
        isMaster_q |=> !line.replyOe && !line.globalDemand)
        else $error("master drives slave demand");

    chk_inactive_silent: assert property (
        !cfg.isActive |=> !line.globalDemand)
        else $error("inactive slave raised demand");

    chk_number_range: assert property (
        !numValid |=> !line.replyOe)
        else $error("invalid demand number drove reply line");

    chk_short_message: assert property (
        msgEnd && bitCnt_q < `BDH_CMD_MIN_BITS |=> diu.rxSizeFlag)
        else $error("short command not flagged");

    chk_gap_fault: assert property (
        gapFault |=> diu.rxFaultFlag)
        else $error("gap in message not flagged");

    chk_word_capture: assert property (
        takeBit |=> word_q[$past(bitCnt_q)] == $past(cpl.replyIn))
        else $error("reply bit not captured");

    chk_deliver_bounded: assert property (
        $rose(st_q == BDH_DELIVER) |->
            (diu.demandPresent throughout ##[0:DELIVER_MAX] deliverDone))
        else $error("demand word delivery overran or lost flag");

endmodule

// ===== bdh_regs.svh
// constants for the bus demand handling block
// assumes a 10 MHz mclk; included by bdh_pkg.sv and bdh_demand.sv
`ifndef BDH_REGS_SVH
`define BDH_REGS_SVH

// --------------------------------------------------------------
// message layout
// --------------------------------------------------------------
`define BDH_FIELD_W 8
`define BDH_CMD_MIN_BITS 5'h18
`define BDH_DEMAND_MAX 5'h18
`define BDH_DEMAND_MIN 5'h01
`define BDH_CNT_SAT 5'h1F
`define BDH_STA_FIRST 5'h00
`define BDH_KIND_FIRST 5'h08
`define BDH_KIND_END 5'h10

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define BDH_CLK_NS 100
`define BDH_GAP_NS 2000
`define BDH_GAP_CYC 6'((`BDH_GAP_NS + `BDH_CLK_NS - 1) / `BDH_CLK_NS)
`define BDH_DIU_DIV 3'h4

`endif

// ===== bdh_pkg.sv
// types shared by the demand handling block
// assumes bdh_regs.svh sits in the same folder
`include "bdh_regs.svh"

package bdh_pkg;

    typedef struct packed
    {
        logic isMaster;
        logic level2En;
        logic isActive;
        logic [4:0] demandNum;
    } bdh_cfg_t;

    typedef struct packed
    {
        logic rxData;
        logic rxStrobe;
        logic msgInProgress;
        logic replyIn;
        logic globalIn;
    } bdh_cpl_t;

    typedef struct packed
    {
        logic replyOut;
        logic replyOe;
        logic globalDemand;
    } bdh_line_t;

    typedef struct packed
    {
        logic demandPresent;
        logic rxData;
        logic rxStrobe;
        logic rxFaultFlag;
        logic rxSizeFlag;
    } bdh_diu_t;

    typedef struct packed
    {
        logic [`BDH_FIELD_W-1:0] stationSel;
        logic [`BDH_FIELD_W-1:0] msgKind;
    } bdh_hdr_t;

    typedef enum logic [1:0]
    {
        BDH_IDLE = 2'b00,
        BDH_DELIVER = 2'b01
    } bdh_state_t;

endpackage

// ===== bdh_cpl_model.sv
// bus coupler model that feeds frames to the demand block
// assumes mclk from the bench and go held for one cycle
module bdh_cpl_model (
    input wire logic mclk,
    input wire logic go,
    input wire logic [4:0] nBits,
    input wire logic [5:0] pace,
    input wire logic [23:0] txWord,
    input wire logic [23:0] rpWord,
    input wire logic globalIn,
    output bdh_pkg::bdh_cpl_t cpl,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    import bdh_pkg::*;
    logic rd;
    logic rs;
    logic mp;
    logic rp;
    int i;
    assign cpl = '{rxData: rd, rxStrobe: rs, msgInProgress: mp,
                   replyIn: rp, globalIn: globalIn};
    // ---------------------------------------------
    // frame generator, one master only drives it
    // ---------------------------------------------
    initial
    begin
        rd = 1'b0;
        rs = 1'b0;
        mp = 1'b0;
        rp = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(posedge mclk);
            if (go)
            begin
                busy <= 1'b1;
                mp <= 1'b1;
                for (i = 0; i < nBits; i++)
                begin
                    rd <= txWord[i];
                    rp <= rpWord[i];
                    repeat (pace - 1) @(posedge mclk);
                    rs <= 1'b1;
                    @(posedge mclk);
                    rs <= 1'b0;
                end
                // released lines flip so a stale level never passes
                rd <= ~rd;
                rp <= ~rp;
                @(posedge mclk);
                mp <= 1'b0;
                busy <= 1'b0;
            end
        end
    end
endmodule

// ===== tb_top.sv
// self-checking bench for the demand block, slave and master roles
// assumes the role is frozen at reset, so each role gets its own reset
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import bdh_pkg::*;
    logic mclk, rst_n, go, pend, gIn, busy;
    logic [4:0] nBits;
    logic [5:0] pace;
    logic [23:0] txWord, rpWord;
    logic [23:0] repVec = '0;
    logic [23:0] dVec = '0;
    int sIdx = 0;
    int dIdx = 0;
    int failCount = 0;
    int cmpCount = 0;
    bdh_cfg_t cfg;
    bdh_cpl_t cpl;
    bdh_line_t line;
    bdh_diu_t diu;
    bdh_hdr_t hdr;
    bdh_cpl_model partner (.mclk(mclk), .go(go), .nBits(nBits),
        .pace(pace), .txWord(txWord), .rpWord(rpWord), .globalIn(gIn),
        .cpl(cpl), .busy(busy));
    bdh_demand DUT (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .cpl(cpl),
        .demandPending(pend), .line(line), .diu(diu), .hdr(hdr));
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // ---------------------------------------------
    // capture reply slots and device side strobes
    // ---------------------------------------------
    always @(posedge mclk)
    begin
        if (cpl.rxStrobe && cpl.msgInProgress && sIdx < 24)
        begin
            repVec[sIdx] <= line.replyOe & line.replyOut;
            sIdx <= sIdx + 1;
        end
        if (diu.rxStrobe && dIdx < 24)
        begin
            dVec[dIdx] <= diu.rxData;
            dIdx <= dIdx + 1;
        end
    end
    task automatic chk(input logic ok, input string msg);
        cmpCount++;
        if (ok !== 1'b1)
        begin
            failCount++;
            $display("[FAIL] %0t ns: %s", $time, msg);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic doReset(input logic m, input logic l2);
        cfg.isMaster <= m;
        cfg.level2En <= l2;
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask
    task automatic frame(input int n, input int p, input logic [23:0] tx,
                         input logic [23:0] rp);
        int w;
        nBits <= 5'(n);
        pace <= 6'(p);
        txWord <= tx;
        rpWord <= rp;
        sIdx <= 0;
        dIdx <= 0;
        repVec <= '0;
        dVec <= '0;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        w = 0;
        @(posedge mclk);
        while (busy && w < 2000)
        begin
            @(posedge mclk);
            w++;
        end
        chk(w < 2000, "frame never ended");
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic testSlots();
        int ks[3] = '{1, 12, 24};
        doReset(1'b0, 1'b1);
        for (int j = 0; j < 3; j++)
        begin
            cfg.demandNum <= 5'(ks[j]);
            @(posedge mclk);
            frame(24, 4, 24'hA5C30F, 24'h000000);
            chk(repVec === 24'(1) << (ks[j] - 1), "slot");
            chk(line.globalDemand === 1'b1, "global mark");
        end
        $display("testSlots done");
    endtask
    task automatic testRefuse();
        logic [4:0] nums[4] = '{5'h00, 5'h19, 5'h18, 5'h18};
        logic [3:0] act = 4'b1011;
        logic [3:0] l2 = 4'b0111;
        for (int j = 0; j < 4; j++)
        begin
            cfg.demandNum <= nums[j];
            cfg.isActive <= act[j];
            cfg.level2En <= l2[j];
            @(posedge mclk);
            frame(24, 4, 24'h0F0F0F, 24'h000000);
            chk(repVec === 24'h000000, "refused slot");
            chk(line.globalDemand === act[j], "inactive");
        end
        $display("testRefuse done");
    endtask
    task automatic testLevel1();
        doReset(1'b1, 1'b0);
        gIn <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(diu.demandPresent === 1'b1, "flag not raised");
        gIn <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(diu.demandPresent === 1'b0, "flag held");
        frame(8, 4, 24'h0000B4, 24'h000000);
        chk(dVec[7:0] === 8'hB4, "echo");
        $display("testLevel1 done");
    endtask
    task automatic testLevel2();
        int w;
        logic [7:0] s, m;
        doReset(1'b1, 1'b1);
        gIn <= 1'b1;
        frame(24, 4, 24'h3C5A96, 24'h1E8C34);
        chk(dVec === 24'h3C5A96, "command echo");
        s = {<<{txWord[7:0]}};
        m = {<<{txWord[15:8]}};
        chk(hdr.stationSel === s, "station");
        chk(hdr.msgKind === m, "kind");
        dIdx <= 0;
        gIn <= 1'b0;
        w = 0;
        @(posedge mclk);
        while (diu.demandPresent && w < 300)
        begin
            @(posedge mclk);
            w++;
        end
        // the last delivered bit lands in the capture one edge later
        @(posedge mclk);
        chk(dIdx === 24 && dVec === 24'h1E8C34, "demand word");
        chk(diu.rxFaultFlag === 1'b0, "fault");
        $display("testLevel2 done");
    endtask
    task automatic testFaults();
        int ns[3] = '{2, 10, 24};
        int ps[3] = '{25, 4, 4};
        logic [2:0] ef = 3'b101;
        logic [2:0] es = 3'b011;
        for (int j = 0; j < 3; j++)
        begin
            frame(ns[j], ps[j], 24'h00FF00, j == 2 ? 24'h000100 : '0);
            repeat (2) @(posedge mclk);
            chk(diu.rxFaultFlag === ef[j], "fault");
            chk(diu.rxSizeFlag === es[j], "size");
        end
        $display("testFaults done");
    endtask
    initial
    begin
        rst_n = 1'b0;
        go = 1'b0;
        pend = 1'b1;
        gIn = 1'b0;
        nBits = 5'h00;
        pace = 6'h04;
        txWord = '0;
        rpWord = '0;
        cfg = '{isMaster: 1'b0, level2En: 1'b1, isActive: 1'b1,
                demandNum: 5'h01};
        @(posedge mclk);
        testSlots();
        testRefuse();
        testLevel1();
        testLevel2();
        testFaults();
        summarize();
    end
    // the whole run needs some 1200 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        failCount++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        summarize();
    end
endmodule
